// ### width_adapter_pkg.sv
// Purpose: Shared constants for the dynamic bus width adapter
// Assumes: Byte enables and size inputs are active low
// Notes:   Lane and width figures and the cycle state type; no registers
package width_adapter_pkg;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned LANES       = 4;
    localparam int unsigned LANE_W      = 8;
    localparam int unsigned ADDR_W      = 30;
    localparam int unsigned OFF_W       = 2;
    localparam int unsigned LINE_BYTES  = 16;
    localparam int unsigned WORD_BYTES  = 4;
    localparam logic [3:0]  BE_NONE     = 4'hF;
    localparam logic [3:0]  BE_ALL      = 4'h0;
    localparam logic [3:0]  LOW_HALF    = 4'h3;
    localparam logic [3:0]  HIGH_HALF   = 4'hC;
    localparam logic [1:0]  OFF_ZERO    = 2'h0;

    typedef enum logic [1:0]
    {
        st_idle  = 2'h0,
        st_bus   = 2'h1,
        st_done  = 2'h3
    } cycle_state_type;
endpackage : width_adapter_pkg

// ### lane_select.sv
// Purpose: Narrows an active-low byte-enable set to the lanes one bus cycle moves
// Assumes: Enable set is contiguous and not empty
// Notes:   Purely combinational
`timescale 1ns/1ns
module lane_select
(
    // Requested lanes, active low
    input  wire logic [3:0] want_n,
    // Bus size inputs, already synchronised
    input  wire logic       size8_n,
    input  wire logic       size16_n,
    // Lanes moved this cycle, active low
    output logic      [3:0] take_n
);
    logic [3:0] want;
    logic [3:0] take;
    logic [3:0] lowest;

    always_comb
    begin
        want   = ~want_n;
        lowest = want & (~want + 4'h1);
        take   = want;
        if (!size8_n)
        begin
            take = lowest;
        end
        else if (!size16_n)
        begin
            if ((want & ~width_adapter_pkg::HIGH_HALF) != 4'h0)
            begin
                take = want & ~width_adapter_pkg::HIGH_HALF;
            end
            else
            begin
                take = want & width_adapter_pkg::HIGH_HALF;
            end
        end
        take_n = ~take;
    end
endmodule : lane_select

// ### dynamic_bus_width_adapter.sv
// Purpose: Splits processor transfers into cycles sized for 32-, 16- and 8-bit buses
// Assumes: Decoder drives the size inputs and ready for every cycle
// Notes:   One transfer in flight; narrow splits walk low lanes first
`timescale 1ns/1ns
module dynamic_bus_width_adapter
#(
    parameter int unsigned LINE_BYTES = width_adapter_pkg::LINE_BYTES
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Request side
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_fill,
    input  wire logic [31:0] req_addr,
    input  wire logic [2:0]  req_len,
    input  wire logic [31:0] req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic      [31:0] rsp_rdata,
    // Processor bus
    output logic             bus_start,
    output logic             bus_write,
    output logic      [29:0] word_address_lines,
    output logic      [3:0]  byte_lane_enables_n,
    output logic      [31:0] bus_wdata,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_ready_n,
    input  wire logic        narrow8_size_n,
    input  wire logic        narrow16_size_n
);
    // Pin synchronisers
    logic [1:0] s8_sync_reg,  s8_sync_next;
    logic [1:0] s16_sync_reg, s16_sync_next;
    logic [1:0] rdy_sync_reg, rdy_sync_next;
    logic [31:0] din_sync1_reg, din_sync2_reg;

    always_comb
    begin
        s8_sync_next  = {s8_sync_reg[0], narrow8_size_n};
        s16_sync_next = {s16_sync_reg[0], narrow16_size_n};
        rdy_sync_next = {rdy_sync_reg[0], bus_ready_n};
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s8_sync_reg   <= 2'h3;
            s16_sync_reg  <= 2'h3;
            rdy_sync_reg  <= 2'h3;
            din_sync1_reg <= 32'h0;
            din_sync2_reg <= 32'h0;
        end
        else
        begin
            s8_sync_reg   <= s8_sync_next;
            s16_sync_reg  <= s16_sync_next;
            rdy_sync_reg  <= rdy_sync_next;
            din_sync1_reg <= bus_rdata;
            din_sync2_reg <= din_sync1_reg;
        end
    end

    wire logic size8_n  = s8_sync_reg[1];
    wire logic size16_n = s16_sync_reg[1];
    wire logic ready    = ~rdy_sync_reg[1];

    // Transfer state
    width_adapter_pkg::cycle_state_type state_reg, state_next;
    logic [29:0] addr_reg, addr_next;
    logic [3:0]  want_reg, want_next;      // pending lanes, active low
    logic [3:0]  tail_reg, tail_next;      // low word part still owed
    logic        tail_pend_reg, tail_pend_next;
    logic [5:0]  fill_left_reg, fill_left_next;
    logic        fill_reg, fill_next, write_reg, write_next;
    logic [63:0] wshift_reg, wshift_next;
    logic [63:0] rbuf_reg, rbuf_next;
    logic        hi_word_reg, hi_word_next;
    logic        start_reg, start_next;
    logic        rsp_reg, rsp_next;
    logic [31:0] rsp_data_reg, rsp_data_next;
    logic [3:0]  be_out_reg, be_out_next;
    logic [31:0] wd_out_reg, wd_out_next;
    logic [29:0] addr_out_reg, addr_out_next;
    logic        write_out_reg, write_out_next;

    logic [3:0] take_n;
    logic [3:0] mask_lo, mask_hi;
    logic [4:0] span;
    logic [5:0] line_bytes_c;

    lane_select u_lane_select
    (
        .want_n   (want_reg),
        .size8_n  (size8_n),
        .size16_n (size16_n),
        .take_n   (take_n)
    );

    function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = be_n[i] ? 8'h00 : 8'hFF;
        end
        return m;
    endfunction : lane_mask

    always_comb
    begin
        state_next     = state_reg;
        addr_next      = addr_reg;
        want_next      = want_reg;
        tail_next      = tail_reg;
        tail_pend_next = tail_pend_reg;
        fill_left_next = fill_left_reg;
        fill_next      = fill_reg;
        write_next     = write_reg;
        wshift_next    = wshift_reg;
        rbuf_next      = rbuf_reg;
        hi_word_next   = hi_word_reg;
        start_next     = 1'b0;
        rsp_next       = 1'b0;
        rsp_data_next  = rsp_data_reg;
        be_out_next    = be_out_reg;
        wd_out_next    = wd_out_reg;
        addr_out_next  = addr_out_reg;
        write_out_next = write_out_reg;
        line_bytes_c   = 6'(LINE_BYTES);
        span           = 5'(req_addr[1:0]) + 5'(req_len);
        mask_lo        = 4'h0;
        mask_hi        = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            mask_lo[i] = (5'(i) >= 5'(req_addr[1:0])) && (5'(i) < span);
            mask_hi[i] = (5'(i) + 5'(width_adapter_pkg::WORD_BYTES) < span);
        end
        unique case (state_reg)
            width_adapter_pkg::st_idle:
            begin
                if (req_valid)
                begin
                    fill_next    = req_fill;
                    write_next   = req_write;
                    wshift_next  = {32'h0, req_wdata} << {req_addr[1:0], 3'h0};
                    rbuf_next    = 64'h0;
                    fill_left_next = line_bytes_c;
                    if (req_fill)
                    begin
                        addr_next      = {req_addr[31:4], 2'h0};
                        want_next      = width_adapter_pkg::BE_ALL;
                        tail_pend_next = 1'b0;
                        hi_word_next   = 1'b0;
                    end
                    else if (mask_hi != 4'h0)
                    begin
                        addr_next      = req_addr[31:2] + 30'h1;
                        want_next      = ~mask_hi;
                        tail_next      = ~mask_lo;
                        tail_pend_next = 1'b1;
                        hi_word_next   = 1'b1;
                    end
                    else
                    begin
                        addr_next      = req_addr[31:2];
                        want_next      = ~mask_lo;
                        tail_pend_next = 1'b0;
                        hi_word_next   = 1'b0;
                    end
                    state_next = width_adapter_pkg::st_done;
                end
            end
            width_adapter_pkg::st_done:
            begin
                // Launch a cycle with the pending lanes
                be_out_next = want_reg;
                wd_out_next = (hi_word_reg ? wshift_reg[63:32] : wshift_reg[31:0])
                              & lane_mask(want_reg);
                start_next  = 1'b1;
                // Cycle definition stands until the next launch
                addr_out_next  = addr_reg;
                write_out_next = write_reg;
                state_next  = width_adapter_pkg::st_bus;
            end
            width_adapter_pkg::st_bus:
            begin
                if (ready)
                begin
                    if (hi_word_reg)
                    begin
                        rbuf_next[63:32] = (rbuf_reg[63:32] & ~lane_mask(take_n))
                                           | (din_sync2_reg & lane_mask(take_n));
                    end
                    else
                    begin
                        rbuf_next[31:0] = (rbuf_reg[31:0] & ~lane_mask(take_n))
                                          | (din_sync2_reg & lane_mask(take_n));
                    end
                    if (fill_reg)
                    begin
                        fill_left_next = fill_left_reg - 6'($countones(~take_n));
                    end
                    if (take_n != want_reg)
                    begin
                        want_next  = want_reg | ~take_n;
                        state_next = width_adapter_pkg::st_done;
                    end
                    else if (fill_reg && fill_left_next != 6'h0)
                    begin
                        addr_next  = addr_reg + 30'h1;
                        want_next  = width_adapter_pkg::BE_ALL;
                        state_next = width_adapter_pkg::st_done;
                    end
                    else if (tail_pend_reg)
                    begin
                        addr_next      = addr_reg - 30'h1;
                        want_next      = tail_reg;
                        tail_pend_next = 1'b0;
                        hi_word_next   = 1'b0;
                        state_next     = width_adapter_pkg::st_done;
                    end
                    else
                    begin
                        rsp_next      = 1'b1;
                        rsp_data_next = 32'(rbuf_next >> {req_addr[1:0], 3'h0});
                        state_next    = width_adapter_pkg::st_idle;
                    end
                end
            end
            default:
            begin
                state_next = width_adapter_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            state_reg     <= width_adapter_pkg::st_idle;
            addr_reg      <= 30'h0;
            want_reg      <= width_adapter_pkg::BE_NONE;
            tail_reg      <= width_adapter_pkg::BE_NONE;
            tail_pend_reg <= 1'b0;
            fill_left_reg <= 6'h0;
            fill_reg      <= 1'b0;
            write_reg     <= 1'b0;
            wshift_reg    <= 64'h0;
            rbuf_reg      <= 64'h0;
            hi_word_reg   <= 1'b0;
            start_reg     <= 1'b0;
            rsp_reg       <= 1'b0;
            rsp_data_reg  <= 32'h0;
            be_out_reg    <= width_adapter_pkg::BE_NONE;
            wd_out_reg    <= 32'h0;
            addr_out_reg  <= 30'h0;
            write_out_reg <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            addr_reg      <= addr_next;
            want_reg      <= want_next;
            tail_reg      <= tail_next;
            tail_pend_reg <= tail_pend_next;
            fill_left_reg <= fill_left_next;
            fill_reg      <= fill_next;
            write_reg     <= write_next;
            wshift_reg    <= wshift_next;
            rbuf_reg      <= rbuf_next;
            hi_word_reg   <= hi_word_next;
            start_reg     <= start_next;
            rsp_reg       <= rsp_next;
            rsp_data_reg  <= rsp_data_next;
            be_out_reg    <= be_out_next;
            wd_out_reg    <= wd_out_next;
            addr_out_reg  <= addr_out_next;
            write_out_reg <= write_out_next;
        end
    end

    // Request side must hold address and length until the response
    logic ready_out_reg;
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ready_out_reg <= 1'b0;
        end
        else
        begin
            ready_out_reg <= (state_next == width_adapter_pkg::st_idle);
        end
    end

    assign req_ready           = ready_out_reg;
    assign rsp_valid           = rsp_reg;
    assign rsp_rdata           = rsp_data_reg;
    assign bus_start           = start_reg;
    assign bus_write           = write_out_reg;
    assign word_address_lines  = addr_out_reg;
    assign byte_lane_enables_n = be_out_reg;
    assign bus_wdata           = wd_out_reg;
endmodule : dynamic_bus_width_adapter

// ### dynamic_bus_width_adapter_checker.sv
// Purpose: Port-level timing checks for the bus width adapter
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound onto every adapter instance
`timescale 1ns/1ns
module dynamic_bus_width_adapter_checker
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Request side
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    // Processor bus
    input wire logic        bus_start,
    input wire logic        bus_write,
    input wire logic [29:0] word_address_lines,
    input wire logic [3:0]  byte_lane_enables_n,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_ready_n
);
    logic [31:0] lane_off;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    assign lane_off = {{8{byte_lane_enables_n[3]}}, {8{byte_lane_enables_n[2]}},
                       {8{byte_lane_enables_n[1]}}, {8{byte_lane_enables_n[0]}}};

    a_start_pulse: assert property (bus_start |=> !bus_start [*3])
        else $error("bus cycle restarted too soon");
    a_start_latency: assert property (req_valid && req_ready |-> ##2 bus_start)
        else $error("accepted request did not start a bus cycle");
    a_ready_wait: assert property (bus_start ##1 bus_ready_n [*3] |-> !rsp_valid && !bus_start)
        else $error("cycle ended without ready");
    a_cycle_stable: assert property (!bus_start |-> $stable({word_address_lines, byte_lane_enables_n, bus_write}))
        else $error("cycle definition moved inside a cycle");
    a_pattern_legal: assert property (bus_start |-> byte_lane_enables_n inside
        {4'hE, 4'hC, 4'h8, 4'h0, 4'hD, 4'h9, 4'h1, 4'hB, 4'h3, 4'h7})
        else $error("empty or split enable pattern");
    a_wdata_clear: assert property (bus_start && bus_write |-> (bus_wdata & lane_off) == 32'h0)
        else $error("write data on a disabled lane");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    a_idle_quiet: assert property (req_ready |-> !bus_start)
        else $error("bus cycle while idle");
endmodule : dynamic_bus_width_adapter_checker

bind dynamic_bus_width_adapter dynamic_bus_width_adapter_checker u_chk (.mclk, .nrst,
    .req_valid, .req_ready, .rsp_valid, .bus_start, .bus_write, .word_address_lines,
    .byte_lane_enables_n, .bus_wdata, .bus_ready_n);

// ### narrow_memory_model.sv
// Purpose: Decoder and 32/16/8-bit memory behind the processor bus
// Assumes: Width chosen per transfer by the bench
// Notes:   Lanes it does not supply carry inverted data
`timescale 1ns/1ns
module narrow_memory_model
(
    // Bench controls
    input wire logic        mclk,
    input wire logic [1:0]  width_sel,
    input wire logic [1:0]  slow,
    // Processor bus
    input wire logic        bus_start,
    input wire logic [29:0] word_address_lines,
    input wire logic [3:0]  byte_lane_enables_n,
    output logic     [31:0] bus_rdata,
    output logic            bus_ready_n,
    output logic            narrow8_size_n,
    output logic            narrow16_size_n
);
    logic [3:0] l;
    logic [7:0] b;
    logic       halfword_select_bit, byte_select_bit;
    logic       lower_byte_select_n, upper_byte_select_n;

    // Narrow-bus address and byte selects decoded from the enables
    assign halfword_select_bit = byte_lane_enables_n[0] & byte_lane_enables_n[1];
    assign lower_byte_select_n = halfword_select_bit ? byte_lane_enables_n[2]
                                                     : byte_lane_enables_n[0];
    assign upper_byte_select_n = halfword_select_bit ? byte_lane_enables_n[3]
                                                     : byte_lane_enables_n[1];
    assign byte_select_bit     = lower_byte_select_n;

    // Lanes one cycle moves at the selected width
    function automatic logic [3:0] lanes(input logic [3:0] en_n, input logic [1:0] ws);
        logic [3:0] e;
        e = ~en_n;
        if (ws == 2'h0)
            return e;
        if (ws != 2'h1)
            return e & (~e + 4'h1);
        return (e[1:0] != 2'h0) ? (e & 4'h3) : (e & 4'hC);
    endfunction : lanes

    assign narrow8_size_n  = ~width_sel[1];
    assign narrow16_size_n = ~width_sel[0];

    initial
    begin
        bus_ready_n = 1'b1;
        bus_rdata   = 32'h0;
        forever
        begin
            @(posedge mclk);
            if (bus_start === 1'b1)
            begin
                #1;
                l = ~byte_lane_enables_n;
                if (width_sel == 2'h1)
                begin
                    l = {2'h0, ~upper_byte_select_n, ~lower_byte_select_n};
                    l = l << {halfword_select_bit, 1'b0};
                end
                else if (width_sel != 2'h0)
                begin
                    l = 4'h1 << {halfword_select_bit, byte_select_bit};
                end
                for (int i = 0; i < 4; i++)
                begin
                    b = {word_address_lines[5:0], 2'(i)} ^ 8'h5A;
                    bus_rdata[i*8 +: 8] = l[i] ? b : ~b;
                end
                repeat (slow) @(posedge mclk);
                @(posedge mclk);
                #1 bus_ready_n = 1'b0;
                @(posedge mclk);
                #1 bus_ready_n = 1'b1;
                @(posedge mclk);
                #1 bus_rdata = ~bus_rdata;
            end
        end
    end
endmodule : narrow_memory_model

// ### dynamic_bus_width_adapter_test.sv
// Purpose: Self-checking bench for the bus width adapter
// Assumes: Memory model answers every bus cycle
// Notes:   Driver queues expected cycles and reads; monitor compares
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dynamic_bus_width_adapter_test;
    typedef struct {bit ce; bit ca; logic [29:0] a; logic [3:0] en; logic [31:0] wd;} cyc_type;
    cyc_type     cyc_q[$], ex;
    logic [31:0] rd_q[$], m;
    int          bad_count, n_checks, seed;
    logic        mclk, nrst, req_valid, req_write, req_fill, req_ready, rsp_valid;
    logic        bus_start, bus_write, bus_ready_n, narrow8_size_n, narrow16_size_n;
    logic [31:0] req_addr, req_wdata, rsp_rdata, bus_rdata, bus_wdata;
    logic [29:0] word_address_lines;
    logic [3:0]  byte_lane_enables_n;
    logic [2:0]  req_len;
    logic [1:0]  width_sel, slow;

    dynamic_bus_width_adapter #(.LINE_BYTES(16)) u_dut (.mclk, .nrst, .req_valid, .req_write,
        .req_fill, .req_addr, .req_len, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
        .bus_start, .bus_write, .word_address_lines, .byte_lane_enables_n, .bus_wdata,
        .bus_rdata, .bus_ready_n, .narrow8_size_n, .narrow16_size_n);
    narrow_memory_model u_mem (.mclk, .width_sel, .slow, .bus_start, .word_address_lines,
        .byte_lane_enables_n, .bus_rdata, .bus_ready_n, .narrow8_size_n, .narrow16_size_n);

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic run(input logic [31:0] a, input int len, input bit wr, input bit fl);
        cyc_type     e;
        logic [3:0]  p;
        logic [31:0] c;
        int          n, lo, hi, d;
        req_wdata = $random(seed);
        slow = 2'($random(seed));
        n = int'(a[1:0]) + len;
        for (int k = 0; k < 4; k++)
        begin
            if (fl)
                begin e.a = {a[31:4], 2'(k)}; lo = 0; hi = 3; end
            else if (k == 0 && n > 4)
                begin e.a = a[31:2] + 30'h1; lo = 0; hi = n - 5; end
            else if (k == 0 || (k == 1 && n > 4))
                begin e.a = a[31:2]; lo = a[1:0]; hi = (n > 4) ? 3 : n - 1; end
            else
                break;
            d = (e.a != a[31:2]) ? 4 : 0;
            p = 4'hF;
            for (int i = lo; i <= hi; i++)
                p[i] = 1'b0;
            while (p != 4'hF)
            begin
                for (int i = 0; i < 4; i++)
                    e.wd[i*8 +: 8] = p[i] ? 8'h0 : req_wdata[(d + i - a[1:0])*8 +: 8];
                e.ce = !(fl && k == 0 && p == 4'h0);
                e.ca = 1'b1;
                e.en = p;
                cyc_q.push_back(e);
                p = p | u_mem.lanes(p, width_sel);
            end
        end
        if (!wr && !fl)
        begin
            m = 32'h0;
            for (int i = 0; i < len; i++)
            begin
                c = a + 32'(i);
                m[i*8 +: 8] = c[7:0] ^ 8'h5A;
            end
            rd_q.push_back(m);
        end
        @(posedge mclk);
        #1;
        for (int t = 0; t < 50 && req_ready !== 1'b1; t++)
            begin @(posedge mclk); #1; end
        `CHK(req_ready, 1'b1)
        req_addr = a;
        req_len = 3'(len);
        req_write = wr;
        req_fill = fl;
        req_valid = 1'b1;
        @(posedge mclk);
        #1 req_valid = 1'b0;
        for (int t = 0; t < 400 && rsp_valid !== 1'b1; t++)
            begin @(posedge mclk); #1; end
        `CHK(rsp_valid, 1'b1)
        @(posedge mclk);
        #1;
        `CHK(cyc_q.size(), 0)
    endtask : run

    always @(posedge mclk)
    begin
        if (bus_start === 1'b1 && cyc_q.size() > 0)
        begin
            ex = cyc_q.pop_front();
            if (ex.ce) `CHK(byte_lane_enables_n, ex.en)
            if (ex.ca) `CHK(word_address_lines, ex.a)
            if (bus_write === 1'b1) `CHK(bus_wdata, ex.wd)
        end
        else if (bus_start === 1'b1) `CHK(bus_start, 1'b0)
        if (rsp_valid === 1'b1 && req_write === 1'b0 && req_fill === 1'b0 && rd_q.size() > 0)
        begin
            m = (req_len == 3'h4) ? 32'hFFFFFFFF : (req_len == 3'h2) ? 32'h0000FFFF : 32'h000000FF;
            `CHK(rsp_rdata & m, rd_q.pop_front())
        end
    end

    initial
    begin
        #500000;
        bad_count++;
        end_of_test();
    end

    initial
    begin
        seed = 32'h38158D90;
        {nrst, req_valid, req_write, req_fill, req_addr, req_wdata, width_sel, slow} = '0;
        req_len = 3'h1;
        repeat (10) @(posedge mclk);
        #1 nrst = 1'b1;
        for (int ws = 0; ws < 4; ws++)
        begin
            width_sel = 2'(ws);
            run(32'($random(seed)), 4, 1'b0, 1'b1);
            for (int o = 0; o < 4; o++)
                for (int l = 1; l <= 4; l = l * 2)
                    for (int wr = 0; wr < 2; wr++)
                        run((32'($random(seed)) & 32'hFFFFFFFC) | 32'(o), l, wr[0], 1'b0);
        end
        end_of_test();
    end
endmodule : dynamic_bus_width_adapter_test
